/* pkg/uart_lms_pkg.sv */
/*
  Constants and shared decoding for the serial line, handshake and status
  block. Assumes a byte-addressed register port with 32-bit data words.
*/
package uart_lms_pkg;
  localparam logic [7:0] ADR_DATA = 8'h00;
  localparam logic [7:0] ADR_INTEN = 8'h04;
  localparam logic [7:0] ADR_LINE = 8'h0C;
  localparam logic [7:0] ADR_MCTL = 8'h10;
  localparam logic [7:0] ADR_MSTS = 8'h14;
  localparam logic [7:0] ADR_FSTS = 8'h18;
  localparam logic [7:0] ADR_FSEL = 8'h30;
  localparam logic [2:0] FS_UART = 3'h0;
  localparam logic [2:0] FS_RS485 = 3'h3;
  localparam int B_RXINV = 9;
  localparam int B_TXINV = 8;
  localparam int B_PSS = 7;
  localparam int B_BRK = 6;
  localparam int B_SPE = 5;
  localparam int B_EPS = 4;
  localparam int B_PEN = 3;
  localparam int B_NSB = 2;
  localparam int B_PAR = 8;
  localparam int B_RTSPIN = 13;
  localparam int B_RTSLV = 9;
  localparam int B_RTS = 1;
  localparam int B_CTSLV = 8;
  localparam int B_CTSPIN = 4;
  localparam int B_CTSFLG = 0;
  localparam int B_ACT = 31;
  localparam int B_RECEIVER_IDLE = 29;
  localparam int B_DRAIN = 28;
  localparam int B_TXOV = 24;
  localparam int B_TXFULL = 23;
  localparam int B_TXEMPTY = 22;
  localparam int B_RXEMPTY = 14;
  localparam int B_PERR = 4;
  localparam int B_IRQEN = 3;
  localparam int B_AUTORTS = 12;
  localparam int B_AUTOCTS = 13;
  localparam int B_DIS = 3;
  localparam int B_AUD = 4;
  localparam logic [31:0] MCTL_RST = 32'h0000_0200;
  localparam logic [31:0] MSTS_RST = 32'h0000_0110;
  localparam logic [31:0] FSTS_RST = 32'hB040_4000;
  localparam logic [7:0] BAUD_DIV_DEF = 8'h0D;
  localparam logic [4:0] BIT_LAST = 5'h0F;
  localparam logic [4:0] MID_LAST = 5'h07;
  localparam logic [4:0] STOP15_LAST = 5'h17;
  localparam logic [4:0] STOP2_LAST = 5'h1F;

  // Parity bit for a character: software, stick, odd or even.
  function automatic logic parity_bit(input logic [8:0] d,
    input logic [1:0] word_length_select, input logic eps, input logic stick_parity_enable,
    input logic parity_source_select);
    logic [7:0] m;
    m = d[7:0] & (8'hFF >> (2'h3 - word_length_select));
    if (parity_source_select)
      parity_bit = d[8];
    else if (stick_parity_enable)
      parity_bit = ~eps;
    else
      parity_bit = ~(^m ^ eps);
  endfunction : parity_bit
endpackage : uart_lms_pkg

/* pkg/tx_if.sv */
/*
  Link between the register core and the frame transmitter. Assumes both
  ends share one clock.
*/
`timescale 1ns/10ps
interface tx_if;
  logic tick;
  logic go;
  logic [7:0] data;
  logic par;
  logic [1:0] word_length_select;
  logic stop_bit_count;
  logic pen;
  logic busy;
  logic line;
  modport mst (output tick, go, data, par, word_length_select, stop_bit_count, pen,
    input busy, line);
  modport slv (input tick, go, data, par, word_length_select, stop_bit_count, pen,
    output busy, line);
endinterface : tx_if

/* hdl/uart_frame_tx.sv */
/*
  Frame transmitter: start bit, 5 to 8 data bits, optional parity, stop.
  Assumes a tick at sixteen times the bit rate and a one-cycle go.
*/
`timescale 1ns/10ps
module uart_frame_tx
  import uart_lms_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  tx_if.slv t
);
  typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} st_t;
  typedef struct packed {
    st_t st;
    logic [4:0] ov;
    logic [2:0] bn;
    logic [7:0] sh;
    logic par;
    logic [1:0] word_length_select;
    logic stop_bit_count;
    logic pen;
    logic line;
  } tx_t;
  tx_t q;
  tx_t d;
  logic [4:0] last;
  logic endb;

  assign t.busy = (q.st != T_IDLE);
  assign t.line = q.line;

  always_comb
  begin
    d = q;
    last = BIT_LAST;
    if (q.st == T_STOP && q.stop_bit_count)
      last = (q.word_length_select == 2'h0) ? STOP15_LAST : STOP2_LAST;
    endb = t.tick && (q.ov == last);
    if (t.tick)
      d.ov = endb ? 5'h00 : q.ov + 5'h01;
    unique case (q.st)
      T_IDLE:
      begin
        d.line = 1'b1;
        d.ov = 5'h00;
        if (t.go)
        begin
          d.st = T_START;
          d.sh = t.data;
          d.par = t.par;
          d.word_length_select = t.word_length_select;
          d.stop_bit_count = t.stop_bit_count;
          d.pen = t.pen;
          d.line = 1'b0;
        end
      end
      T_START:
        if (endb)
        begin
          d.st = T_DATA;
          d.bn = 3'h0;
          d.line = q.sh[0];
          d.sh = {1'b0, q.sh[7:1]};
        end
      T_DATA:
        if (endb)
        begin
          if (q.bn == {1'b0, q.word_length_select} + 3'h4)
          begin
            d.st = q.pen ? T_PAR : T_STOP;
            d.line = q.pen ? q.par : 1'b1;
          end
          else
          begin
            d.bn = q.bn + 3'h1;
            d.line = q.sh[0];
            d.sh = {1'b0, q.sh[7:1]};
          end
        end
      T_PAR:
        if (endb)
        begin
          d.st = T_STOP;
          d.line = 1'b1;
        end
      T_STOP:
        if (endb)
          d.st = T_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      q <= '{st: T_IDLE, line: 1'b1, default: '0};
    else
      q <= d;
  end
endmodule : uart_frame_tx

/* hdl/uart_line_modem_status.sv */
/*
  Register core of the serial port: line format, transmit queue, receiver,
  request/clear handshake and status. Assumes a one-cycle register port
  on the core clock; serial pins arrive asynchronously.
*/
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
// Summary of operation
// - Receive-invert set flips incoming data before sampling.
// - Transmit-invert set flips outgoing data.
// - Parity source 0 means hardware parity, 1 means software parity.
// - Software parity sends data bit 8, returns received parity at bit 8.
// - Break forces transmit output low; transmitter keeps running.
// - Stick parity sends and expects 0 if even-select, else 1.
// - Normal parity is odd with even-select 0, even with 1.
// - Parity enable adds a parity bit on send; on receive it is checked only with hardware parity.
// - Stop count 1 gives 1.5 stops for 5 bits, 2 otherwise.
// - Word length codes 0 to 3 give 5 to 8 data bits.
// - Status bit shows the level driven on the request pin.
// - Request active level 0 drives high when active; resets to 1.
// - Software request bit 0 makes request active, 1 inactive.
// - Software request ignored under automatic flow or direction control.
// - Clear active level 0 means high active; resets to 1.
// - Status bit mirrors clear pin when clear function is selected.
// - Clear change sets flag, raises handshake interrupt; write 1 clears.
// - Active status clears only when disabled and both sides idle.
// - Receiver idle bit reads 1 when idle, resets to 1.
// - Drained bit is 1 when queue empty and last stop bit sent.
// - Data write to full queue sets overflow flag; write 1 clears.
// - Transmit queue holds 16 bytes and is full at 16.
module uart_line_modem_status
  import uart_lms_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter logic [7:0] BAUD_DIV = BAUD_DIV_DEF
)
(
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic RXD_I,
  output logic TXD_O,
  input wire logic CTS_N_I,
  output logic RTS_N_O,
  output logic MODEM_IRQ_O
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} rx_st_t;
  typedef struct packed {
    logic [1:0] word_length_select;
    logic stop_bit_count;
    logic pen;
    logic eps;
    logic stick_parity_enable;
    logic brk;
    logic parity_source_select;
    logic txinv;
    logic rxinv;
    logic rts_bit;
    logic rts_lvl;
    logic cts_lvl;
    logic cts_flag;
    logic irq_en;
    logic auto_rts;
    logic auto_cts;
    logic [2:0] fsel;
    logic dis;
    logic auto_direction_control;
    logic txov;
    logic perr;
    logic [2:0] cts_s;
    logic [1:0] rx_s;
    logic [7:0] div;
    logic tick;
    logic [CW-1:0] cnt;
    logic [PW-1:0] rp;
    logic [PW-1:0] wp;
    logic tx_go;
    rx_st_t rx_st;
    logic [4:0] rx_ov;
    logic [2:0] rx_bn;
    logic [8:0] rx_sh;
    logic [8:0] rx_dat;
    logic rx_full;
    logic txd;
    logic rts_n;
    logic irq;
    logic [31:0] rdata;
  } core_t;
  core_t q;
  core_t d;
  logic [8:0] fifo [DEPTH];
  tx_if tx ();
  logic wr_data;
  logic push;
  logic rxb;
  logic rx_end;
  logic rx_last_bit;
  logic port_act;
  logic cts_act;
  logic req_act;
  logic drained;
  logic [4:0] rx_last;

  uart_frame_tx u_tx (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .t(tx)
  );

  assign tx.tick = q.tick;
  assign tx.go = q.tx_go;
  assign tx.data = fifo[q.rp][7:0];
  assign tx.par = parity_bit(fifo[q.rp], q.word_length_select, q.eps, q.stick_parity_enable, q.parity_source_select);
  assign tx.word_length_select = q.word_length_select;
  assign tx.stop_bit_count = q.stop_bit_count;
  assign tx.pen = q.pen;
  assign RDATA_O = q.rdata;
  assign TXD_O = q.txd;
  assign RTS_N_O = q.rts_n;
  assign MODEM_IRQ_O = q.irq;

  always_comb
  begin
    d = q;
    wr_data = WR_I && (ADDR_I == ADR_DATA);
    push = wr_data && (q.cnt != FULL);
    rxb = q.rx_s[1] ^ q.rxinv;
    cts_act = q.cts_s[1] ^ q.cts_lvl;
    port_act = !(q.dis && !tx.busy && !q.tx_go && q.rx_st == R_IDLE);
    drained = (q.cnt == '0) && !tx.busy && !q.tx_go;
    d.rx_s = {q.rx_s[0], RXD_I};
    d.cts_s = {q.cts_s[1:0], CTS_N_I};
    d.tick = (q.div == BAUD_DIV - 8'h01);
    d.div = d.tick ? 8'h00 : q.div + 8'h01;

    if (WR_I && ADDR_I == ADR_FSTS && WDATA_I[B_TXOV])
      d.txov = 1'b0;
    if (wr_data && q.cnt == FULL)
      d.txov = 1'b1;
    d.tx_go = !q.tx_go && !tx.busy && (q.cnt != '0) && !q.dis
      && (!q.auto_cts || cts_act);
    if (push)
      d.wp = q.wp + PW'(1);
    if (q.tx_go)
      d.rp = q.rp + PW'(1);
    d.cnt = q.cnt + CW'(push) - CW'(q.tx_go);

    if (WR_I && ADDR_I == ADR_MSTS && WDATA_I[B_CTSFLG])
      d.cts_flag = 1'b0;
    if (q.cts_s[1] != q.cts_s[2])
      d.cts_flag = 1'b1;
    d.irq = q.cts_flag && q.irq_en;

    if (q.fsel == FS_UART && q.auto_rts)
      req_act = !q.rx_full;
    else if (q.fsel == FS_RS485 && q.auto_direction_control)
      req_act = tx.busy || q.tx_go;
    else
      req_act = !q.rts_bit;
    d.rts_n = req_act ^ q.rts_lvl;
    d.txd = q.brk ? 1'b0 : (tx.line ^ q.txinv);

    rx_last = (q.rx_st == R_START) ? MID_LAST : BIT_LAST;
    rx_end = q.tick && (q.rx_ov == rx_last);
    rx_last_bit = (q.rx_bn == {1'b0, q.word_length_select} + 3'h4);
    if (q.tick)
      d.rx_ov = rx_end ? 5'h00 : q.rx_ov + 5'h01;
    if (RD_I && ADDR_I == ADR_DATA)
      d.rx_full = 1'b0;
    if (WR_I && ADDR_I == ADR_FSTS && WDATA_I[B_PERR])
      d.perr = 1'b0;
    unique case (q.rx_st)
      R_IDLE:
      begin
        d.rx_ov = 5'h00;
        if (!q.dis && !rxb)
        begin
          d.rx_st = R_START;
          d.rx_sh = 9'h000;
        end
      end
      R_START:
        if (rx_end)
        begin
          d.rx_st = rxb ? R_IDLE : R_DATA;
          d.rx_bn = 3'h0;
        end
      R_DATA:
        if (rx_end)
        begin
          d.rx_sh[q.rx_bn] = rxb;
          d.rx_bn = q.rx_bn + 3'h1;
          if (rx_last_bit)
            d.rx_st = q.pen ? R_PAR : R_STOP;
        end
      R_PAR:
        if (rx_end)
        begin
          d.rx_sh[B_PAR] = rxb;
          d.rx_st = R_STOP;
          if (!q.parity_source_select && rxb != parity_bit(q.rx_sh, q.word_length_select, q.eps,
              q.stick_parity_enable, q.parity_source_select))
            d.perr = 1'b1;
        end
      R_STOP:
        if (rx_end)
        begin
          d.rx_st = R_IDLE;
          d.rx_dat = q.rx_sh;
          d.rx_full = 1'b1;
        end
    endcase

    if (WR_I)
    begin
      unique case (ADDR_I)
        ADR_LINE:
        begin
          {d.rxinv, d.txinv, d.parity_source_select, d.brk} = WDATA_I[B_RXINV:B_BRK];
          {d.stick_parity_enable, d.eps, d.pen, d.stop_bit_count} = WDATA_I[B_SPE:B_NSB];
          d.word_length_select = WDATA_I[1:0];
        end
        ADR_INTEN:
        begin
          d.irq_en = WDATA_I[B_IRQEN];
          d.auto_rts = WDATA_I[B_AUTORTS];
          d.auto_cts = WDATA_I[B_AUTOCTS];
        end
        ADR_MCTL:
        begin
          d.rts_lvl = WDATA_I[B_RTSLV];
          d.rts_bit = WDATA_I[B_RTS];
        end
        ADR_MSTS:
          d.cts_lvl = WDATA_I[B_CTSLV];
        ADR_FSEL:
        begin
          d.fsel = WDATA_I[2:0];
          d.dis = WDATA_I[B_DIS];
          d.auto_direction_control = WDATA_I[B_AUD];
        end
        default:
          d.fsel = d.fsel;
      endcase
    end

    d.rdata = 32'h0000_0000;
    if (RD_I)
    begin
      unique case (ADDR_I)
        ADR_DATA:
        begin
          d.rdata[7:0] = q.rx_dat[7:0];
          d.rdata[B_PAR] = q.pen && q.parity_source_select && q.rx_dat[B_PAR];
        end
        ADR_LINE:
        begin
          d.rdata[B_RXINV:B_BRK] = {q.rxinv, q.txinv, q.parity_source_select, q.brk};
          d.rdata[B_SPE:B_NSB] = {q.stick_parity_enable, q.eps, q.pen, q.stop_bit_count};
          d.rdata[1:0] = q.word_length_select;
        end
        ADR_INTEN:
        begin
          d.rdata[B_IRQEN] = q.irq_en;
          d.rdata[B_AUTORTS] = q.auto_rts;
          d.rdata[B_AUTOCTS] = q.auto_cts;
        end
        ADR_MCTL:
        begin
          d.rdata[B_RTSPIN] = q.rts_n;
          d.rdata[B_RTSLV] = q.rts_lvl;
          d.rdata[B_RTS] = q.rts_bit;
        end
        ADR_MSTS:
        begin
          d.rdata[B_CTSLV] = q.cts_lvl;
          d.rdata[B_CTSPIN] = (q.fsel == FS_UART) && q.cts_s[1];
          d.rdata[B_CTSFLG] = q.cts_flag;
        end
        ADR_FSTS:
        begin
          d.rdata[B_ACT] = port_act;
          d.rdata[B_RECEIVER_IDLE] = (q.rx_st == R_IDLE);
          d.rdata[B_DRAIN] = drained;
          d.rdata[B_TXOV] = q.txov;
          d.rdata[B_TXFULL] = (q.cnt == FULL);
          d.rdata[B_TXEMPTY] = (q.cnt == '0);
          d.rdata[B_RXEMPTY] = !q.rx_full;
          d.rdata[B_PERR] = q.perr;
        end
        ADR_FSEL:
          d.rdata[B_AUD:0] = {q.auto_direction_control, q.dis, q.fsel};
        default:
          d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (push)
      fifo[q.wp] <= WDATA_I[8:0];
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      q <= '{rts_lvl: MCTL_RST[B_RTSLV], cts_lvl: MSTS_RST[B_CTSLV],
        cts_s: 3'h7, rx_s: 2'h3, rx_st: R_IDLE, txd: 1'b1,
        default: '0};
    else
      q <= d;
  end

  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RST_I);

  a_break_low: assert property (
    q.brk |=> !TXD_O)
    else $error("break did not hold the line low");
  a_tx_invert: assert property (
    !q.brk |=> TXD_O == ($past(tx.line) ^ $past(q.txinv)))
    else $error("transmit line level wrong");
  a_rts_status: assert property (
    (RD_I && ADDR_I == ADR_MCTL) |=> RDATA_O[B_RTSPIN] == $past(RTS_N_O))
    else $error("request status differs from pin");
  a_rts_manual: assert property (
    (q.fsel == FS_UART && !q.auto_rts)
      |=> RTS_N_O == !($past(q.rts_bit) ^ $past(q.rts_lvl)))
    else $error("request pin wrong in manual mode");
  a_cts_change: assert property (
    (q.cts_s[1] != q.cts_s[2]) |=> q.cts_flag ##1 (q.irq == $past(q.irq_en)))
    else $error("clear change not flagged");
  a_tx_overflow: assert property (
    (wr_data && q.cnt == FULL) |=> q.txov && $stable(q.wp))
    else $error("overflow not flagged or queue written");
  a_queue_bound: assert property (
    q.cnt <= FULL)
    else $error("queue count above depth");
  a_active_set: assert property (
    (RD_I && ADDR_I == ADR_FSTS && !q.dis) |=> RDATA_O[B_ACT])
    else $error("active status low while enabled");
  a_drain_busy: assert property (
    (RD_I && ADDR_I == ADR_FSTS && q.cnt != '0) |=> !RDATA_O[B_DRAIN])
    else $error("drained while queue holds data");
  a_rx_busy: assert property (
    (RD_I && ADDR_I == ADR_FSTS && q.rx_st != R_IDLE)
      |=> !RDATA_O[B_RECEIVER_IDLE])
    else $error("receiver idle while receiving");
endmodule : uart_line_modem_status

/* verification/serial_peer.sv */
/*
  Serial peer model: sends characters on the receive line, decodes frames
  seen on the transmit line and drives the clear-to-send pin.
  Assumes the bench sets nb, tinv and rinv only while the port is disabled.
*/
`timescale 1ns/10ps
module serial_peer #(
  parameter int BIT = 32
)
(
  input wire logic clk_i,
  input wire logic txd_i,
  input wire logic rts_n_i,
  output logic rxd_o,
  output logic cts_n_o
);
  logic tinv = 1'b0;
  logic rinv = 1'b0;
  logic bitq = 1'b1;
  logic cts_q = 1'b1;
  int nb = 8;
  int cyc = 0;
  int st = 0;
  int per = 0;
  logic [8:0] sh;
  logic [8:0] q[$];
  wire logic line = txd_i ^ tinv;
  assign rxd_o = bitq ^ rinv;
  assign cts_n_o = cts_q;
  always @(posedge clk_i) cyc <= cyc + 1;
  // A start edge that is gone by mid bit is a glitch and is dropped.
  always
  begin
    @(negedge line);
    repeat (BIT / 2) @(posedge clk_i);
    if (line === 1'b0)
    begin
      per = cyc - st;
      st = cyc;
      sh = '0;
      for (int k = 0; k < nb; k++)
      begin
        repeat (BIT) @(posedge clk_i);
        sh[k] = line;
      end
      q.push_back(sh);
    end
  end
  task automatic send(input logic [8:0] b, input int n);
    while (rts_n_i !== 1'b0) @(posedge clk_i);
    bitq <= 1'b0;
    repeat (BIT) @(posedge clk_i);
    for (int k = 0; k < n; k++)
    begin
      bitq <= b[k];
      repeat (BIT) @(posedge clk_i);
    end
    bitq <= 1'b1;
    repeat (BIT) @(posedge clk_i);
  endtask : send
endmodule : serial_peer

/* verification/tb.sv */
/*
  Self-checking bench for the serial line, handshake and status block.
  Assumes the package, the link interface, the design and the peer model
  are compiled before it.
*/
`timescale 1ns/10ps
module tb
  import uart_lms_pkg::*;
;
  localparam int BIT = 32;
  logic CORE_CLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic [7:0] ADDR_I = 8'h00;
  logic [31:0] WDATA_I = 32'h0;
  logic WR_I = 1'b0;
  logic RD_I = 1'b0;
  logic [31:0] RDATA_O;
  logic RXD_I, TXD_O, CTS_N_I, RTS_N_O, MODEM_IRQ_O;
  int num_errors = 0;
  int total_checks = 0;
  int e;
  logic [31:0] v;
  logic [8:0] d0, d1;
  logic [9:0] l;
  always #20 CORE_CLK_I = ~CORE_CLK_I;
  uart_line_modem_status #(.DEPTH(16), .BAUD_DIV(8'h02)) uut (
    .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .RXD_I(RXD_I), .TXD_O(TXD_O), .CTS_N_I(CTS_N_I), .RTS_N_O(RTS_N_O),
    .MODEM_IRQ_O(MODEM_IRQ_O));
  serial_peer #(.BIT(BIT)) peer (.clk_i(CORE_CLK_I), .txd_i(TXD_O),
    .rts_n_i(RTS_N_O), .rxd_o(RXD_I), .cts_n_o(CTS_N_I));
  task automatic chk(input string n, input logic [31:0] s,
    input logic [31:0] x);
    total_checks++;
    if (s !== x)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge CORE_CLK_I);
    WR_I <= 1'b0;
    @(posedge CORE_CLK_I);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CORE_CLK_I);
    RD_I <= 1'b0;
    #1 d = RDATA_O;
    @(posedge CORE_CLK_I);
  endtask : rd
  task automatic poll(input int b, input logic x);
    logic [31:0] s;
    for (int k = 0; k < 5000; k++)
    begin
      rd(ADR_FSTS, s);
      if (s[b] === x) break;
    end
    chk("status", {31'h0, s[b]}, {31'h0, x});
  endtask : poll
  task automatic dis;
    wr(ADR_FSEL, 32'h8);
    poll(B_ACT, 1'b0);
  endtask : dis
  task automatic en;
    wr(ADR_FSEL, 32'h0);
    repeat (BIT) @(posedge CORE_CLK_I);
  endtask : en
  function automatic logic [8:0] fexp(input logic [5:0] c,
    input logic [8:0] d);
    int n;
    logic [7:0] m;
    logic p;
    n = 5 + c[1:0];
    m = d[7:0] & 8'((9'h001 << n) - 9'h001);
    p = c[5] ? d[8] : (c[4] ? ~c[3] : ^m ^ ~c[3]);
    fexp = c[2] ? ({1'b0, m} | (9'(p) << n)) : {1'b0, m};
  endfunction : fexp
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (100000) @(posedge CORE_CLK_I);
    num_errors++;
    stop_test();
  end
  initial
  begin
    void'($urandom(36));
    repeat (6) @(posedge CORE_CLK_I);
    RST_I <= 1'b0;
    @(posedge CORE_CLK_I);
    chk("rts_pin", {31'h0, RTS_N_O}, 32'h0);
    rd(ADR_MCTL, v);
    chk("mctl", v, MCTL_RST);
    rd(ADR_MSTS, v);
    chk("msts", v, MSTS_RST);
    rd(ADR_FSTS, v);
    chk("fsts", v, FSTS_RST);
    rd(8'h08, v);
    chk("unmapped", v, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      dis();
      peer.rinv <= i[0];
      wr(ADR_LINE, {22'h0, i[0], 9'h08B});
      en();
      d0 = 9'($urandom);
      fork
        peer.send(d0, 9);
        begin
          repeat (4 * BIT) @(posedge CORE_CLK_I);
          rd(ADR_FSTS, v);
          chk("rx_idle", {31'h0, v[B_RECEIVER_IDLE]}, 32'h0);
        end
      join
      repeat (8) @(posedge CORE_CLK_I);
      rd(ADR_DATA, v);
      chk("rx_char", v & 32'h1FF, {23'h0, d0});
    end
    wr(ADR_LINE, 32'h21B);
    for (int j = 0; j < 2; j++)
    begin
      d0 = 9'($urandom);
      d0[8] = ^d0[7:0] ^ j[0];
      peer.send(d0, 9);
      rd(ADR_FSTS, v);
      chk("perr", {31'h0, v[B_PERR]}, {31'h0, j[0]});
      rd(ADR_DATA, v);
      chk("rx_par", v & 32'h1FF, {24'h0, d0[7:0]});
      wr(ADR_FSTS, 32'h10);
      rd(ADR_FSTS, v);
      chk("perr_clr", {31'h0, v[B_PERR]}, 32'h0);
    end
    for (int i = 0; i < 64; i++)
    begin
      l = {1'b0, i[0] ^ i[3], i[5], 1'b0, i[4], i[3], i[2], i[1] ^ i[4],
        i[1:0]};
      dis();
      peer.tinv <= l[8];
      peer.rinv <= 1'b0;
      peer.nb <= 5 + i[1:0] + i[2];
      wr(ADR_LINE, {22'h0, l});
      en();
      peer.q.delete();
      d0 = 9'($urandom);
      d1 = 9'($urandom);
      wr(ADR_DATA, {23'h0, d0});
      wr(ADR_DATA, {23'h0, d1});
      poll(B_DRAIN, 1'b1);
      chk("frame0", {23'h0, peer.q[0]}, {23'h0, fexp(i[5:0], d0)});
      chk("frame1", {23'h0, peer.q[1]}, {23'h0, fexp(i[5:0], d1)});
      e = BIT * (6 + i[1:0] + i[2]) +
        (l[2] ? (i[1:0] == 0 ? BIT * 3 / 2 : 2 * BIT) : BIT);
      chk("period", {31'h0, peer.per >= e && peer.per <= e + 8}, 32'h1);
    end
    wr(ADR_LINE, 32'h43);
    wr(ADR_DATA, $urandom & 32'hFF);
    for (int k = 0; k < 8; k++)
    begin
      repeat (BIT) @(posedge CORE_CLK_I);
      chk("break", {31'h0, TXD_O}, 32'h0);
    end
    poll(B_DRAIN, 1'b1);
    wr(ADR_LINE, 32'h3);
    wr(ADR_INTEN, 32'h8);
    peer.cts_q <= 1'b0;
    repeat (6) @(posedge CORE_CLK_I);
    chk("irq", {31'h0, MODEM_IRQ_O}, 32'h1);
    rd(ADR_MSTS, v);
    chk("msts_chg", v, 32'h101);
    wr(ADR_MSTS, 32'h101);
    rd(ADR_MSTS, v);
    chk("msts_clr", v, 32'h100);
    chk("irq_clr", {31'h0, MODEM_IRQ_O}, 32'h0);
    wr(ADR_INTEN, 32'h2000);
    peer.q.delete();
    peer.cts_q <= 1'b1;
    repeat (4) @(posedge CORE_CLK_I);
    wr(ADR_DATA, $urandom & 32'hFF);
    repeat (3 * BIT) @(posedge CORE_CLK_I);
    chk("gated", peer.q.size(), 0);
    peer.cts_q <= 1'b0;
    poll(B_DRAIN, 1'b1);
    chk("sent", peer.q.size(), 1);
    wr(ADR_INTEN, 32'h0);
    wr(ADR_FSEL, 32'h8);
    peer.q.delete();
    for (int k = 0; k < 17; k++)
    begin
      if (k == 16)
      begin
        rd(ADR_FSTS, v);
        chk("full", v & 32'h0180_0000, 32'h0080_0000);
      end
      wr(ADR_DATA, $urandom & 32'hFF);
    end
    rd(ADR_FSTS, v);
    chk("ovf", v & 32'h0100_0000, 32'h0100_0000);
    wr(ADR_FSTS, 32'h0100_0000);
    rd(ADR_FSTS, v);
    chk("ovf_clr", v & 32'h0100_0000, 32'h0);
    wr(ADR_FSEL, 32'h0);
    poll(B_DRAIN, 1'b1);
    chk("count", peer.q.size(), 16);
    for (int k = 0; k < 4; k++)
    begin
      dis();
      wr(ADR_MCTL, {22'h0, k[1], 7'h0, k[0], 1'b0});
      en();
      rd(ADR_MCTL, v);
      chk("rts_pin", {31'h0, RTS_N_O}, {31'h0, k[1] ~^ k[0]});
      chk("rts_sts", {31'h0, v[B_RTSPIN]}, {31'h0, k[1] ~^ k[0]});
    end
    wr(ADR_INTEN, 32'h1000);
    repeat (4) @(posedge CORE_CLK_I);
    chk("auto_rts", {31'h0, RTS_N_O}, 32'h0);
    wr(ADR_INTEN, 32'h0);
    wr(ADR_MCTL, 32'h200);
    wr(ADR_FSEL, 32'h13);
    repeat (4) @(posedge CORE_CLK_I);
    chk("aud_idle", {31'h0, RTS_N_O}, 32'h1);
    wr(ADR_DATA, $urandom & 32'hFF);
    repeat (BIT) @(posedge CORE_CLK_I);
    chk("aud_busy", {31'h0, RTS_N_O}, 32'h0);
    poll(B_DRAIN, 1'b1);
    wr(ADR_FSEL, 32'h0);
    wr(ADR_LINE, 32'hFFFF_FCFF);
    rd(ADR_LINE, v);
    chk("line_rsv", v, 32'h0000_00FF);
    stop_test();
  end
endmodule : tb
